// file: verilog/cic_consts.vh
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH

`define CIC_ERR_EN_WIDTH 24
`define CIC_ERR_EN_RESET 24'h000000
`define CIC_ROM_EN_BIT 0
`define CIC_MAP_EN_BIT 1
`define CIC_SER_EN_BIT 2

`define CIC_CLK_PERIOD_NS 10
`define CIC_MAP_PERIOD_NS 426600
// 426600 ns over a 10 ns clock, sized for the 16-bit period timer
`define CIC_MAP_PERIOD_CYCLES 16'hA6A4

`define CIC_ADDR_WIDTH 6
`define CIC_WORD_WIDTH 24
`define CIC_MAP_LAST_ADDR 6'h38
`define CIC_STATUS_ADDR 6'h00
`define CIC_DATA_ADDR 6'h02
`define CIC_MCLK_COUNT_ADDR 6'h08
`define CIC_ROM_LAST_ADDR 6'h3F

`define CIC_MODE_WIDTH 4
`define CIC_MODE_SINGLE 4'h2
`define CIC_MODE_IDLE 4'h4

`define CIC_CRC_POLY 8'h07
`define CIC_CRC_INIT 8'h00

`endif

// file: verilog/cic_crc8_word.v
`timescale 1ns/1ns
`include "cic_consts.vh"

module cic_crc8_word
(
    crcIn,
    dataIn,
    crcOut
);
    input wire [7:0] crcIn;
    input wire [`CIC_WORD_WIDTH-1:0] dataIn;
    output reg [7:0] crcOut;

    integer i;

    // Bit-serial CRC-8, MSB first, unrolled over one word per clock
    always @*
    begin
        crcOut = crcIn;
        for (i = `CIC_WORD_WIDTH - 1; i >= 0; i = i - 1)
        begin
            if (crcOut[7] ^ dataIn[i])
            begin
                crcOut = {crcOut[6:0], 1'b0} ^ `CIC_CRC_POLY;
            end
            else
            begin
                crcOut = {crcOut[6:0], 1'b0};
            end
        end
    end
endmodule

// file: verilog/cic_config_integrity_check.v
`timescale 1ns/1ns
`include "cic_consts.vh"

module cic_config_integrity_check
#(
    parameter [15:0] CHECK_PERIOD_CYCLES = `CIC_MAP_PERIOD_CYCLES
)
(
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire errEnWrStrobe,
    input wire [`CIC_ERR_EN_WIDTH-1:0] errEnWrData,
    output reg [`CIC_ERR_EN_WIDTH-1:0] errEnRdData,
    input wire hostRegWrite,
    input wire calUpdate,
    input wire [`CIC_MODE_WIDTH-1:0] modeField,
    input wire continuousReadoutFlag,
    output wire [`CIC_ADDR_WIDTH-1:0] mapRdAddr,
    input wire [`CIC_WORD_WIDTH-1:0] mapRdData,
    output wire [`CIC_ADDR_WIDTH-1:0] romRdAddr,
    input wire [`CIC_WORD_WIDTH-1:0] romRdData,
    input wire serialFrameDone,
    input wire serialFrameIsWrite,
    input wire serialFrameCrcOk,
    output wire serialCheckEnable,
    output wire serialWriteAllowed,
    output reg serialCrcFailSet,
    output reg mapCheckFailSet,
    output reg romCheckFailSet,
    output reg romCheckDone,
    output reg mapRefValid,
    output wire scanBusy
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ROM = 2'b01;
    localparam [1:0] ST_MAP = 2'b10;

    // Read-only registers are left out of the map checksum
    function isWritable;
        input [`CIC_ADDR_WIDTH-1:0] addr;
        begin
            isWritable = (addr != `CIC_STATUS_ADDR) && (addr != `CIC_DATA_ADDR) &&
                (addr != `CIC_MCLK_COUNT_ADDR);
        end
    endfunction

    reg [`CIC_ERR_EN_WIDTH-1:0] errEn_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`CIC_ADDR_WIDTH-1:0] scanAddr_reg;
    reg [`CIC_ADDR_WIDTH-1:0] scanAddr_next;
    reg [7:0] crcAcc_reg;
    reg [7:0] crcAcc_next;
    reg [7:0] mapRef_reg;
    reg [7:0] mapRef_next;
    reg scanIsRef_reg;
    reg scanIsRef_next;
    reg scanDirty_reg;
    reg scanDirty_next;
    reg recomputePend_reg;
    reg recomputePend_next;
    reg checkDue_reg;
    reg checkDue_next;
    reg [15:0] timer_reg;
    reg [15:0] timer_next;
    reg [`CIC_MODE_WIDTH-1:0] modePrev_reg;
    reg contReadPrev_reg;
    reg romDone_next;
    reg refValid_next;
    reg mapFail_next;
    reg romFail_next;

    wire romEnable = errEn_reg[`CIC_ROM_EN_BIT];
    wire mapEnable = errEn_reg[`CIC_MAP_EN_BIT];
    wire [`CIC_WORD_WIDTH-1:0] scanData = (state_reg == ST_ROM) ? romRdData : mapRdData;
    wire [7:0] crcStep;
    wire modeEndEvent;
    wire contExitEvent;
    wire recomputeEvent;
    wire timerExpired;
    wire lastMapWord;
    wire lastRomWord;
    wire [7:0] mapCrcFinal;

    cic_crc8_word crcEngine
    (
        .crcIn(crcAcc_reg),
        .dataIn(scanData),
        .crcOut(crcStep)
    );

    assign mapRdAddr = scanAddr_reg;
    assign romRdAddr = scanAddr_reg;
    assign scanBusy = (state_reg != ST_IDLE);

    assign serialCheckEnable = errEn_reg[`CIC_SER_EN_BIT];
    // Bad checksum only blocks the write while checking is on
    assign serialWriteAllowed = ~serialCheckEnable | serialFrameCrcOk;

    assign modeEndEvent = (modePrev_reg == `CIC_MODE_SINGLE) &&
        (modeField == `CIC_MODE_IDLE);
    assign contExitEvent = contReadPrev_reg & ~continuousReadoutFlag;
    assign recomputeEvent = hostRegWrite | calUpdate | errEnWrStrobe |
        modeEndEvent | contExitEvent;

    assign timerExpired = (timer_reg == CHECK_PERIOD_CYCLES - 16'h0001);
    assign lastMapWord = (scanAddr_reg == `CIC_MAP_LAST_ADDR);
    assign lastRomWord = (scanAddr_reg == `CIC_ROM_LAST_ADDR);
    assign mapCrcFinal = isWritable(scanAddr_reg) ? crcStep : crcAcc_reg;

    // Period timer runs only while the map check is enabled
    always @*
    begin
        timer_next = timer_reg;
        if (!mapEnable)
        begin
            timer_next = 16'h0000;
        end
        else if (timerExpired)
        begin
            timer_next = 16'h0000;
        end
        else
        begin
            timer_next = timer_reg + 16'h0001;
        end
    end

    always @*
    begin
        state_next = state_reg;
        scanAddr_next = scanAddr_reg;
        crcAcc_next = crcAcc_reg;
        mapRef_next = mapRef_reg;
        scanIsRef_next = scanIsRef_reg;
        scanDirty_next = scanDirty_reg | (scanBusy & recomputeEvent);
        recomputePend_next = recomputePend_reg;
        checkDue_next = checkDue_reg;
        romDone_next = romCheckDone;
        refValid_next = mapRefValid;
        mapFail_next = 1'b0;
        romFail_next = 1'b0;

        case (state_reg)
            ST_IDLE:
            begin
                scanAddr_next = {`CIC_ADDR_WIDTH{1'b0}};
                crcAcc_next = `CIC_CRC_INIT;
                // An event on the start edge already makes the next scan stale
                scanDirty_next = recomputeEvent;
                if (!romCheckDone)
                begin
                    state_next = ST_ROM;
                end
                else if (recomputePend_reg)
                begin
                    // Clear before the OR below, so an event now is kept
                    recomputePend_next = 1'b0;
                    scanIsRef_next = 1'b1;
                    state_next = ST_MAP;
                end
                else if (checkDue_reg && mapRefValid && mapEnable)
                begin
                    checkDue_next = 1'b0;
                    scanIsRef_next = 1'b0;
                    state_next = ST_MAP;
                end
            end
            ST_ROM:
            begin
                if (lastRomWord)
                begin
                    // Last ROM word carries the stored checksum in its low byte
                    romDone_next = 1'b1;
                    romFail_next = (crcAcc_reg != romRdData[7:0]) & romEnable;
                    state_next = ST_IDLE;
                end
                else
                begin
                    crcAcc_next = crcStep;
                    scanAddr_next = scanAddr_reg + {{(`CIC_ADDR_WIDTH-1){1'b0}}, 1'b1};
                end
            end
            ST_MAP:
            begin
                if (lastMapWord)
                begin
                    state_next = ST_IDLE;
                    if (scanIsRef_reg)
                    begin
                        mapRef_next = mapCrcFinal;
                        refValid_next = ~(scanDirty_reg | recomputeEvent);
                    end
                    else if (!(scanDirty_reg | recomputeEvent))
                    begin
                        // A write mid-scan would give a false mismatch
                        mapFail_next = (mapCrcFinal != mapRef_reg) & mapEnable;
                    end
                end
                else
                begin
                    crcAcc_next = mapCrcFinal;
                    scanAddr_next = scanAddr_reg + {{(`CIC_ADDR_WIDTH-1){1'b0}}, 1'b1};
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase

        // Set wins over the clear taken above
        if (recomputeEvent)
        begin
            recomputePend_next = 1'b1;
        end
        if (mapEnable && timerExpired)
        begin
            checkDue_next = 1'b1;
        end
        if (!mapEnable)
        begin
            checkDue_next = 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            errEn_reg <= `CIC_ERR_EN_RESET;
            errEnRdData <= `CIC_ERR_EN_RESET;
            state_reg <= ST_IDLE;
            scanAddr_reg <= {`CIC_ADDR_WIDTH{1'b0}};
            crcAcc_reg <= `CIC_CRC_INIT;
            mapRef_reg <= `CIC_CRC_INIT;
            scanIsRef_reg <= 1'b0;
            scanDirty_reg <= 1'b0;
            recomputePend_reg <= 1'b1;
            checkDue_reg <= 1'b0;
            timer_reg <= 16'h0000;
            modePrev_reg <= `CIC_MODE_IDLE;
            contReadPrev_reg <= 1'b0;
            romCheckDone <= 1'b0;
            mapRefValid <= 1'b0;
            mapCheckFailSet <= 1'b0;
            romCheckFailSet <= 1'b0;
            serialCrcFailSet <= 1'b0;
        end
        else if (ce)
        begin
            if (errEnWrStrobe)
            begin
                errEn_reg <= errEnWrData;
                errEnRdData <= errEnWrData;
            end
            state_reg <= state_next;
            scanAddr_reg <= scanAddr_next;
            crcAcc_reg <= crcAcc_next;
            mapRef_reg <= mapRef_next;
            scanIsRef_reg <= scanIsRef_next;
            scanDirty_reg <= scanDirty_next;
            recomputePend_reg <= recomputePend_next;
            checkDue_reg <= checkDue_next;
            timer_reg <= timer_next;
            modePrev_reg <= modeField;
            contReadPrev_reg <= continuousReadoutFlag;
            romCheckDone <= romDone_next;
            mapRefValid <= refValid_next;
            mapCheckFailSet <= mapFail_next;
            romCheckFailSet <= romFail_next;
            serialCrcFailSet <= serialFrameDone & serialFrameIsWrite & ~serialFrameCrcOk &
                serialCheckEnable;
        end
    end
endmodule

// file: dv/cic_config_integrity_check_checker.sv
`timescale 1ns/1ns
`include "cic_consts.vh"
module cic_config_integrity_check_checker
(
    input wire mclk,
    input wire rst_n,
    input wire ce,
    input wire errEnWrStrobe,
    input wire [23:0] errEnWrData,
    input wire [23:0] errEnRdData,
    input wire hostRegWrite,
    input wire calUpdate,
    input wire [3:0] modeField,
    input wire continuousReadoutFlag,
    input wire serialFrameDone,
    input wire serialFrameIsWrite,
    input wire serialFrameCrcOk,
    input wire serialCheckEnable,
    input wire serialWriteAllowed,
    input wire serialCrcFailSet,
    input wire mapCheckFailSet,
    input wire romCheckFailSet,
    input wire romCheckDone,
    input wire mapRefValid,
    input wire scanBusy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence badWr;
        ce && serialFrameDone && serialFrameIsWrite && !serialFrameCrcOk;
    endsequence
    sequence refEvt;
        ce && (hostRegWrite || calUpdate || errEnWrStrobe);
    endsequence
    en_write_a: assert property (ce && errEnWrStrobe |=> errEnRdData == $past(errEnWrData))
        else $error("enable readback wrong");
    ser_enable_a: assert property (ce && errEnWrStrobe |=> serialCheckEnable == $past(errEnWrData[2]))
        else $error("serial enable wrong");
    ser_allow_a: assert property (serialWriteAllowed == (!serialCheckEnable || serialFrameCrcOk))
        else $error("write allow wrong");
    ser_fail_a: assert property (badWr ##0 serialCheckEnable |=> serialCrcFailSet)
        else $error("serial fail missing");
    ser_quiet_a: assert property (serialCrcFailSet |-> $past(serialCheckEnable))
        else $error("serial fail while disabled");
    map_quiet_a: assert property (mapCheckFailSet |-> $past(errEnRdData[1]))
        else $error("map fail while disabled");
    rom_quiet_a: assert property (romCheckFailSet |-> $past(errEnRdData[0]))
        else $error("rom fail while disabled");
    rom_done_a: assert property ($rose(rst_n) |-> ##[1:100] romCheckDone)
        else $error("rom check never done");
    wr_scan_a: assert property (refEvt |-> ##[1:3] scanBusy)
        else $error("no recompute scan");
    ref_valid_a: assert property (refEvt |-> ##[1:200] mapRefValid)
        else $error("reference not rebuilt");
    mode_scan_a: assert property (ce && $past(modeField) == `CIC_MODE_SINGLE
        && modeField == `CIC_MODE_IDLE |-> ##[1:3] scanBusy)
        else $error("no scan after mode change");
    cont_scan_a: assert property (ce && $fell(continuousReadoutFlag) |-> ##[1:3] scanBusy)
        else $error("no scan after readout exit");
endmodule

bind cic_config_integrity_check cic_config_integrity_check_checker u_chk
(
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .errEnWrStrobe(errEnWrStrobe),
    .errEnWrData(errEnWrData), .errEnRdData(errEnRdData), .hostRegWrite(hostRegWrite),
    .calUpdate(calUpdate), .modeField(modeField), .continuousReadoutFlag(continuousReadoutFlag),
    .serialFrameDone(serialFrameDone), .serialFrameIsWrite(serialFrameIsWrite),
    .serialFrameCrcOk(serialFrameCrcOk), .serialCheckEnable(serialCheckEnable),
    .serialWriteAllowed(serialWriteAllowed), .serialCrcFailSet(serialCrcFailSet),
    .mapCheckFailSet(mapCheckFailSet), .romCheckFailSet(romCheckFailSet),
    .romCheckDone(romCheckDone), .mapRefValid(mapRefValid), .scanBusy(scanBusy)
);

// file: dv/cic_config_integrity_check_tb_top.sv
`timescale 1ns/1ns
`include "cic_consts.vh"
module cic_config_integrity_check_tb_top;
    logic mclk, rst_n, ce, errEnWrStrobe, hostRegWrite, calUpdate, contRd, romBad;
    logic serialFrameDone, serialFrameIsWrite, serialFrameCrcOk, serialCheckEnable;
    logic serialWriteAllowed, serialCrcFailSet, mapCheckFailSet, romCheckFailSet;
    logic romCheckDone, mapRefValid, scanBusy;
    logic [23:0] errEnWrData, errEnRdData;
    logic [23:0] mapMem [0:63];
    logic [3:0] modeField;
    logic [5:0] mapRdAddr, romRdAddr;
    int error_cnt, samples_checked, mapHits, romHits, serHits, b, m;

    // Short period keeps each check cycle at 64 clocks
    cic_config_integrity_check #(.CHECK_PERIOD_CYCLES(16'h0040)) dut
    (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .errEnWrStrobe(errEnWrStrobe),
        .errEnWrData(errEnWrData), .errEnRdData(errEnRdData), .hostRegWrite(hostRegWrite),
        .calUpdate(calUpdate), .modeField(modeField), .continuousReadoutFlag(contRd),
        .mapRdAddr(mapRdAddr), .mapRdData(mapMem[mapRdAddr]), .romRdAddr(romRdAddr),
        .romRdData((romBad && romRdAddr == 6'h3F) ? 24'h000001 : 24'h000000),
        .serialFrameDone(serialFrameDone), .serialFrameIsWrite(serialFrameIsWrite),
        .serialFrameCrcOk(serialFrameCrcOk), .serialCheckEnable(serialCheckEnable),
        .serialWriteAllowed(serialWriteAllowed), .serialCrcFailSet(serialCrcFailSet),
        .mapCheckFailSet(mapCheckFailSet), .romCheckFailSet(romCheckFailSet),
        .romCheckDone(romCheckDone), .mapRefValid(mapRefValid), .scanBusy(scanBusy)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (mapCheckFailSet === 1'b1) mapHits++;
        if (romCheckFailSet === 1'b1) romHits++;
        if (serialCrcFailSet === 1'b1) serHits++;
    end

    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task regWr(input logic [23:0] d);
        @(posedge mclk);
        errEnWrStrobe <= 1'b1;
        errEnWrData <= d;
        @(posedge mclk);
        errEnWrStrobe <= 1'b0;
        @(posedge mclk);
        chk("enables", errEnRdData, d);
    endtask

    // Skip the first edges, the old reference may still read valid there
    task waitFor(input bit rom);
        int i;
        repeat (3) @(posedge mclk);
        for (i = 0; i < 400; i++)
        begin
            @(posedge mclk);
            if (rom ? romCheckDone === 1'b1 : (mapRefValid === 1'b1 && scanBusy === 1'b0))
                break;
        end
        if (i == 400)
        begin
            chk("wait", 24'h0, 24'h1);
            summarize();
        end
    endtask

    task quiet(input string nm, input logic [23:0] exp);
        m = mapHits;
        repeat (300) @(posedge mclk);
        chk(nm, {23'h0, mapHits != m}, exp);
    endtask

    // Map word is corrupted on the same edge as the recompute event; k 4 and 5 raise no event
    task trig(input int k);
        @(posedge mclk);
        modeField <= (k == 2) ? `CIC_MODE_SINGLE : `CIC_MODE_IDLE;
        contRd <= (k == 3);
        @(posedge mclk);
        hostRegWrite <= (k == 0);
        calUpdate <= (k == 1);
        modeField <= `CIC_MODE_IDLE;
        contRd <= 1'b0;
        mapMem[16 + k] <= mapMem[16 + k] ^ 24'h000001;
        @(posedge mclk);
        hostRegWrite <= 1'b0;
        calUpdate <= 1'b0;
    endtask

    task doReset(input logic bad);
        @(posedge mclk);
        rst_n <= 1'b0;
        romBad <= bad;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    initial
    begin
        {rst_n, errEnWrStrobe, hostRegWrite, calUpdate, contRd, romBad} = 6'h00;
        {serialFrameDone, serialFrameIsWrite, serialFrameCrcOk, ce} = 4'h1;
        errEnWrData = 24'h0;
        modeField = `CIC_MODE_IDLE;
        {error_cnt, samples_checked, mapHits, romHits, serHits} = '0;
        for (b = 0; b < 64; b++)
            mapMem[b] = 24'(b * 3);
        doReset(1'b0);
        chk("reset enables", errEnRdData, 24'h0);
        waitFor(1'b1);
        chk("rom fail", 24'(romHits), 24'h0);
        regWr(24'h000002);
        waitFor(1'b0);
        quiet("clean map", 24'h0);
        mapMem[`CIC_DATA_ADDR] <= 24'h0000FF;
        quiet("read-only word", 24'h0);
        for (b = 0; b < 4; b++)
        begin
            trig(b);
            waitFor(1'b0);
            quiet("recompute", 24'h0);
        end
        trig(4);
        quiet("periodic", 24'h1);
        regWr(24'h0);
        waitFor(1'b0);
        trig(5);
        quiet("map disabled", 24'h0);
        $display("map tests done");
        for (b = 0; b < 4; b++)
        begin
            regWr({21'h0, b[1], 2'b00});
            @(posedge mclk);
            serialFrameDone <= 1'b1;
            serialFrameIsWrite <= b[0];
            serialFrameCrcOk <= 1'b0;
            m = serHits;
            @(posedge mclk);
            serialFrameDone <= 1'b0;
            chk("write allowed", {23'h0, serialWriteAllowed}, {23'h0, !b[1]});
            repeat (2) @(posedge mclk);
            chk("serial fail", 24'(serHits - m), {23'h0, b[1] & b[0]});
        end
        // Strobe while the clock enable is low must be ignored
        @(posedge mclk);
        ce <= 1'b0;
        errEnWrStrobe <= 1'b1;
        errEnWrData <= 24'h000001;
        @(posedge mclk);
        ce <= 1'b1;
        errEnWrStrobe <= 1'b0;
        @(posedge mclk);
        chk("frozen enables", errEnRdData, 24'h000004);
        $display("serial tests done");
        m = romHits;
        doReset(1'b1);
        regWr(24'h000001);
        waitFor(1'b1);
        repeat (3) @(posedge mclk);
        chk("rom report", 24'(romHits - m), 24'h1);
        m = romHits;
        doReset(1'b1);
        waitFor(1'b1);
        chk("rom done", {23'h0, romCheckDone}, 24'h000001);
        chk("rom masked", 24'(romHits - m), 24'h0);
        $display("rom tests done");
        summarize();
    end
endmodule
